/* prsm_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "prsm_params.svh"
module prsm_top import prsm_pkg::*; #(
  parameter int A_W = 6,
  parameter int B_W = 13
) (
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic           ce,
  input  wire logic [7:0]     s_axi_awaddr,
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  input  wire logic [7:0]     s_axi_araddr,
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  input  wire logic           vco_tick,
  input  wire logic [A_W-1:0] swallow_count,
  input  wire logic [B_W-1:0] main_count,
  input  wire logic           fb_delayed,
  input  wire logic           ref_div_delayed,
  input  wire logic           pfd_up,
  input  wire logic           pfd_down,
  input  wire logic           first_reference_input,
  input  wire logic           second_reference_input,
  input  wire logic           diff_mode,
  input  wire logic           ref_sel_second,
  input  wire logic           sel_ref_ok,
  input  wire logic           unsel_ref_ok,
  input  wire logic           first_reference_input_freq_ok,
  input  wire logic           second_reference_input_freq_ok,
  input  wire logic           clk_freq_ok,
  input  wire logic           digital_lock_indication,
  input  wire logic           holdover_active,
  input  wire logic           lock_detect_pin_cmp,
  output logic                feedback_out,
  output logic                status_pin,
  output logic                irq
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  prsm_bus_type            state_r;
  logic [7:0]              presc_r;
  logic [7:0]              sel_reg_r;
  logic [7:0]              lock_r;
  logic [`PRSM_EV_W-1:0]   stat_r;
  logic [`PRSM_EV_W-1:0]   stat_nxt;
  logic [`PRSM_EV_W-1:0]   mask_r;
  logic [`PRSM_EV_W-1:0]   ev;
  logic                    dld_prev_r;
  logic                    hold_prev_r;
  logic                    wr_go;
  logic                    rd_go;
  logic [5:0]              wr_idx;
  logic [5:0]              rd_idx;
  logic                    wr_lane;
  logic                    sel_refused;
  logic                    rd_clr;
  logic [31:0]             rd_val;
  logic                    rd_hit;
  logic                    wr_hit;
  logic [5:0]              sel;
  logic [5:0]              idx;
  logic                    mirror;
  logic                    inv;
  logic                    lvl;
  logic                    pin_nxt;
  logic                    sel_ref_clk;
  logic                    unsel_ref_clk;
  logic                    presc_pulse;
  logic                    swallow_pulse;

  // ----------------------------------------
  // feedback divider
  // ----------------------------------------
  prsm_fbdiv #(
    .A_W (A_W),
    .B_W (B_W)
  ) u_fbdiv (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .ce            (ce),
    .vco_tick      (vco_tick),
    .presc_code    (prsm_presc_type'(presc_r[2:0])),
    .bypass        (presc_r[`PRSM_BIT_BYPASS]),
    .swallow_count (swallow_count),
    .main_count    (main_count),
    .presc_out     (presc_pulse),
    .swallow_out   (swallow_pulse),
    .fb_out        (feedback_out)
  );

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  assign wr_go         = ce && state_r == BUS_IDLE && s_axi_awvalid && s_axi_wvalid;
  assign rd_go         = ce && state_r == BUS_IDLE && s_axi_arvalid && !wr_go;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = state_r == BUS_WRESP;
  assign s_axi_rvalid  = state_r == BUS_RRESP;
  assign wr_idx        = s_axi_awaddr[7:2];
  assign rd_idx        = s_axi_araddr[7:2];
  assign wr_lane       = wr_go && s_axi_wstrb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= BUS_IDLE;
    end else if (ce) begin
      case (state_r)
        BUS_IDLE: begin
          if (wr_go) begin
            state_r <= BUS_WRESP;
          end else if (rd_go) begin
            state_r <= BUS_RRESP;
          end
        end
        BUS_WRESP: begin
          if (s_axi_bready) begin
            state_r <= BUS_IDLE;
          end
        end
        BUS_RRESP: begin
          if (s_axi_rready) begin
            state_r <= BUS_IDLE;
          end
        end
        default: state_r <= BUS_IDLE;
      endcase
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    case (wr_idx)
      `PRSM_IDX_PRESC, `PRSM_IDX_SEL, `PRSM_IDX_LOCK: wr_hit = 1'b1;
      `PRSM_IDX_IRQ_STAT, `PRSM_IDX_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (rd_idx)
      `PRSM_IDX_PRESC:     rd_val = {24'h000000, presc_r};
      `PRSM_IDX_SEL:       rd_val = {24'h000000, sel_reg_r};
      `PRSM_IDX_LOCK:      rd_val = {24'h000000, lock_r};
      `PRSM_IDX_IRQ_STAT:  rd_val = {28'h0000000, stat_r};
      `PRSM_IDX_IRQ_MASK:  rd_val = {28'h0000000, mask_r};
      default:             rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= `PRSM_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bresp <= wr_hit ? `PRSM_RESP_OKAY : `PRSM_RESP_DECERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PRSM_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? `PRSM_RESP_OKAY : `PRSM_RESP_DECERR;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  assign sel_refused = wr_lane && wr_idx == `PRSM_IDX_SEL && lock_r[`PRSM_BIT_LOCK];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_r <= `PRSM_RST_PRESC;
    end else if (wr_lane && wr_idx == `PRSM_IDX_PRESC) begin
      presc_r <= s_axi_wdata[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_reg_r <= `PRSM_RST_SEL;
    end else if (wr_lane && wr_idx == `PRSM_IDX_SEL && !sel_refused) begin
      sel_reg_r <= s_axi_wdata[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_r <= `PRSM_RST_LOCK;
    end else if (wr_lane && wr_idx == `PRSM_IDX_LOCK) begin
      lock_r <= s_axi_wdata[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= `PRSM_RST_MASK;
    end else if (wr_lane && wr_idx == `PRSM_IDX_IRQ_MASK) begin
      mask_r <= s_axi_wdata[`PRSM_EV_W-1:0];
    end
  end

  // ----------------------------------------
  // events and interrupt
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dld_prev_r  <= 1'b0;
      hold_prev_r <= 1'b0;
    end else if (ce) begin
      dld_prev_r  <= digital_lock_indication;
      hold_prev_r <= holdover_active;
    end
  end

  assign ev[0] = ce && digital_lock_indication && !dld_prev_r;
  assign ev[1] = ce && !digital_lock_indication && dld_prev_r;
  assign ev[2] = ce && holdover_active && !hold_prev_r;
  assign ev[3] = sel_refused;
  assign rd_clr   = rd_go && rd_idx == `PRSM_IDX_IRQ_STAT;
  // set wins over the read clear
  assign stat_nxt = (rd_clr ? '0 : stat_r) | ev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= '0;
    end else if (ce) begin
      stat_r <= stat_nxt;
    end
  end

  assign irq = |(stat_r & mask_r);

  // ----------------------------------------
  // status pin selector
  // ----------------------------------------
  assign sel           = sel_reg_r[7:`PRSM_SEL_LSB];
  // differential reference arrives on the first input
  assign sel_ref_clk   = (ref_sel_second && !diff_mode) ? second_reference_input
                                                        : first_reference_input;
  assign unsel_ref_clk = ref_sel_second ? first_reference_input : second_reference_input;

  always_comb begin
    lvl    = 1'b0;
    mirror = sel[5:4] == 2'b11 && sel[3:2] != 2'b00;
    idx    = mirror ? {2'b10, sel[3:0]} : sel;
    // mirrored levels flip, the and-terms 0x29 and 0x2A and the clock 0x24 do not
    inv    = mirror && idx != 6'h24 && idx != 6'h29 && idx != 6'h2A;
    case (idx)
      6'h01: lvl = fb_delayed;
      6'h02: lvl = ref_div_delayed;
      6'h03: lvl = swallow_pulse;
      6'h04: lvl = presc_pulse;
      6'h05: lvl = pfd_up;
      6'h06: lvl = pfd_down;
      6'h20: lvl = 1'b0;
      6'h21: lvl = first_reference_input;
      6'h22: lvl = second_reference_input && !diff_mode;
      6'h23: lvl = sel_ref_clk;
      6'h24: lvl = unsel_ref_clk && !diff_mode;
      6'h25: lvl = sel_ref_ok;
      6'h26: lvl = unsel_ref_ok && !diff_mode;
      6'h27: lvl = first_reference_input_freq_ok;
      6'h28: lvl = second_reference_input_freq_ok;
      6'h29: lvl = first_reference_input_freq_ok && second_reference_input_freq_ok;
      6'h2A: lvl = digital_lock_indication && sel_ref_ok && clk_freq_ok;
      6'h2B: lvl = clk_freq_ok;
      6'h2C: lvl = ref_sel_second;
      6'h2D: lvl = digital_lock_indication;
      6'h2E: lvl = holdover_active;
      6'h2F: lvl = lock_detect_pin_cmp;
      6'h30: lvl = 1'b1;
      6'h31: lvl = first_reference_input;
      6'h32: lvl = second_reference_input && !diff_mode;
      6'h33: lvl = sel_ref_clk;
      default: lvl = 1'b0;
    endcase
    pin_nxt = lvl ^ inv;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_pin <= 1'b0;
    end else if (ce) begin
      status_pin <= pin_nxt;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_presc_reset: assert property ($past(!aresetn) |-> presc_r[2:0] == 3'h6)
    else $error("prescaler code not default after reset");
  a_sel_locked: assert property (sel_refused |=> $stable(sel_reg_r) && stat_r[3])
    else $error("selector changed while locked");
  a_pin_ground: assert property (ce && !sel[5] && sel > 6'h06 |=> !status_pin)
    else $error("unlisted low code not ground");
  a_pin_pfd_up: assert property (ce && sel == 6'h05 |=> status_pin == $past(pfd_up))
    else $error("detector up pulse not routed");
  a_pin_swallow: assert property (ce && sel == 6'h03 |=> status_pin == $past(swallow_pulse))
    else $error("swallow pulse not routed");
  a_pin_presc: assert property (ce && sel == 6'h04 |=> status_pin == $past(presc_pulse))
    else $error("prescaler pulse not routed");
  a_pin_first_reference_input: assert property (ce && sel == 6'h21 ##1 ce && sel == 6'h21
    |=> status_pin == $past(first_reference_input))
    else $error("first reference clock not routed");
  a_pin_status: assert property (ce && sel == 6'h27 |=> status_pin == $past(first_reference_input_freq_ok))
    else $error("reference frequency status wrong");
  a_pin_and: assert property (ce && sel == 6'h2A |=> status_pin == $past(
    digital_lock_indication && sel_ref_ok && clk_freq_ok))
    else $error("lock and-term wrong");
  a_pin_refsel: assert property (ce && sel == 6'h2C |=> status_pin == $past(ref_sel_second))
    else $error("selected reference level wrong");
  a_pin_hold: assert property (ce && sel == 6'h2E |=> status_pin == $past(holdover_active))
    else $error("holdover level wrong");
  a_pin_high: assert property (ce && sel == 6'h30 |=> status_pin)
    else $error("supply level not high");
  a_pin_inverted: assert property (ce && sel == 6'h3C |=> status_pin == !$past(ref_sel_second))
    else $error("mirrored level not inverted");
  a_irq_level: assert property (ce && |(ev & mask_r) |=> irq)
    else $error("unmasked event gave no interrupt");

  c_write_done: cover property (wr_go ##[1:8] s_axi_bvalid && s_axi_bready);
  c_read_clear: cover property (rd_clr && |stat_r);
  c_irq_rise: cover property ($rose(irq));
  c_sel_refused: cover property (sel_refused);
endmodule // prsm_top
`default_nettype wire

/* prsm_params.svh */
`ifndef PRSM_PARAMS_SVH
`define PRSM_PARAMS_SVH
// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define PRSM_IDX_PRESC     6'h16
`define PRSM_IDX_SEL       6'h17
`define PRSM_IDX_LOCK      6'h1D
`define PRSM_IDX_IRQ_STAT  6'h20
`define PRSM_IDX_IRQ_MASK  6'h21
// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define PRSM_RST_PRESC     8'h06
`define PRSM_RST_SEL       8'h00
`define PRSM_RST_LOCK      8'h00
`define PRSM_RST_MASK      4'h0
`define PRSM_BIT_BYPASS    3
`define PRSM_BIT_LOCK      7
`define PRSM_SEL_LSB       2
`define PRSM_EV_W          4
// ----------------------------------------
// bus responses
// ----------------------------------------
`define PRSM_RESP_OKAY     2'h0
`define PRSM_RESP_DECERR   2'h3
`endif

/* prsm_pkg.sv */
package prsm_pkg;
  // ----------------------------------------
  // prescaler codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    PRSM_FD1  = 3'h0,
    PRSM_FD2  = 3'h1,
    PRSM_DM3  = 3'h2,
    PRSM_DM5  = 3'h3,
    PRSM_DM9  = 3'h4,
    PRSM_DM17 = 3'h5,
    PRSM_DM33 = 3'h6,
    PRSM_FD3  = 3'h7
  } prsm_presc_type;
  // ----------------------------------------
  // bus states, gray from idle to each response
  // ----------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'h0,
    BUS_WRESP = 2'h1,
    BUS_RRESP = 2'h2
  } prsm_bus_type;
endpackage

/* prsm_fbdiv.sv */
`timescale 1ns/10ps
`default_nettype none
module prsm_fbdiv import prsm_pkg::*; #(
  parameter int A_W = 6,
  parameter int B_W = 13
) (
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic           ce,
  input  wire logic           vco_tick,
  input  wire prsm_presc_type presc_code,
  input  wire logic           bypass,
  input  wire logic [A_W-1:0] swallow_count,
  input  wire logic [B_W-1:0] main_count,
  output logic                presc_out,
  output logic                swallow_out,
  output logic                fb_out
);
  // ----------------------------------------
  // prescaler modulus
  // ----------------------------------------
  logic [5:0]     p_cnt_r;
  logic [5:0]     base;
  logic [5:0]     modulus;
  logic           dual;
  logic           p_wrap;
  logic [A_W-1:0] a_left_r;
  logic [B_W-1:0] b_cnt_r;
  logic [B_W-1:0] b_lim;
  logic           b_wrap;

  always_comb begin
    dual = 1'b1;
    case (presc_code)
      PRSM_FD1:  begin base = 6'h01; dual = 1'b0; end
      PRSM_FD2:  begin base = 6'h02; dual = 1'b0; end
      PRSM_FD3:  begin base = 6'h03; dual = 1'b0; end
      PRSM_DM3:  base = 6'h02;
      PRSM_DM5:  base = 6'h04;
      PRSM_DM9:  base = 6'h08;
      PRSM_DM17: base = 6'h10;
      PRSM_DM33: base = 6'h20;
      default:   base = 6'h01;
    endcase
    // larger ratio while swallow count remains
    modulus = base + {5'h00, dual && (a_left_r != '0)};
  end

  assign p_wrap = vco_tick && (p_cnt_r >= modulus - 6'h01);
  // main counter forced to one when bypassed
  assign b_lim  = bypass ? B_W'(1) : ((main_count == '0) ? B_W'(1) : main_count);
  assign b_wrap = p_wrap && (b_cnt_r >= b_lim - B_W'(1));

  // ----------------------------------------
  // counters
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p_cnt_r <= 6'h00;
    end else if (ce && vco_tick) begin
      p_cnt_r <= p_wrap ? 6'h00 : p_cnt_r + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      b_cnt_r  <= '0;
      a_left_r <= '0;
    end else if (ce && p_wrap) begin
      if (b_wrap) begin
        b_cnt_r  <= '0;
        a_left_r <= swallow_count;
      end else begin
        b_cnt_r <= b_cnt_r + B_W'(1);
        if (a_left_r != '0) begin
          a_left_r <= a_left_r - A_W'(1);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_out   <= 1'b0;
      swallow_out <= 1'b0;
      fb_out      <= 1'b0;
    end else if (ce) begin
      presc_out   <= p_wrap;
      swallow_out <= p_wrap && !b_wrap && (a_left_r == A_W'(1));
      fb_out      <= b_wrap;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_bypass_each: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && bypass && p_wrap |=> fb_out)
    else $error("bypass did not pass every prescaler pulse");
  a_fd1_every: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && presc_code == PRSM_FD1 && vco_tick |=> presc_out)
    else $error("divide by one missed a tick");
  a_dm_high_ratio: assert property (@(posedge aclk) disable iff (!aresetn)
    presc_code == PRSM_DM9 && a_left_r != '0 |-> modulus == 6'h09)
    else $error("dual modulus high ratio wrong");
endmodule // prsm_fbdiv
`default_nettype wire

/* prescaler_and_status_pin_mux_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module prescaler_and_status_pin_mux_bench;
  logic        aclk, aresetn, ce, awv, wv, bready, arv, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, fb_out, pin, irq;
  logic [5:0]  swc;
  logic [12:0] mainc;
  logic [15:0] src;
  int          mismatches, checks_done;

  prsm_top i_prsm_top (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .vco_tick(1'b1), .swallow_count(swc), .main_count(mainc),
    .fb_delayed(src[0]), .ref_div_delayed(src[1]), .pfd_up(src[2]), .pfd_down(src[3]),
    .first_reference_input(src[4]), .second_reference_input(src[5]),
    .diff_mode(src[6]), .ref_sel_second(src[7]), .sel_ref_ok(src[8]),
    .unsel_ref_ok(src[9]), .first_reference_input_freq_ok(src[10]), .second_reference_input_freq_ok(src[11]),
    .clk_freq_ok(src[12]), .digital_lock_indication(src[13]),
    .holdover_active(src[14]), .lock_detect_pin_cmp(src[15]),
    .feedback_out(fb_out), .status_pin(pin), .irq(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ----------------------------------------
  // checking and reporting
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic hang();
    mismatches++;
    tally_and_finish();
  endtask

  // ----------------------------------------
  // bus master
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      if (bvalid === 1'b1) break;
      aw |= (awready === 1'b1);
      w |= (wready === 1'b1);
      @(posedge aclk);
      if (aw) awv <= 1'b0;
      if (w) wv <= 1'b0;
    end
    if (n == 50) hang();
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar;
    ar = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      if (rvalid === 1'b1) break;
      ar |= (arready === 1'b1);
      @(posedge aclk);
      if (ar) arv <= 1'b0;
    end
    if (n == 50) hang();
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic wrchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    axi_wr(a, d, r);
    check("bresp", {30'h0, r}, {30'h0, e});
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check("rdata", d, e);
    check("rresp", {30'h0, r}, 32'h0);
  endtask

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic int div_exp(input logic [2:0] c, input logic sw);
    int b;
    b = (c == 3'h0) ? 1 : (c == 3'h1) ? 2 : (c == 3'h7) ? 3 : (1 << (c - 1));
    return b + int'(c inside {[3'h2:3'h6]} && sw);
  endfunction

  function automatic logic pin_exp(input logic [5:0] c, input logic [15:0] s);
    logic d, e;
    d = s[6];
    case (c >= 6'h34 ? c - 6'h10 : c)
      6'h01: e = s[0];
      6'h02: e = s[1];
      6'h05: e = s[2];
      6'h06: e = s[3];
      6'h21, 6'h31: e = s[4];
      6'h22, 6'h32: e = !d && s[5];
      6'h23, 6'h33: e = (s[7] && !d) ? s[5] : s[4];
      6'h24: e = !d && (s[7] ? s[4] : s[5]);
      6'h25: e = s[8];
      6'h26: e = !d && s[9];
      6'h27: e = s[10];
      6'h28: e = s[11];
      6'h29: e = s[10] & s[11];
      6'h2A: e = s[13] & s[8] & s[12];
      6'h2B: e = s[12];
      6'h2C: e = s[7];
      6'h2D: e = s[13];
      6'h2E: e = s[14];
      6'h2F: e = s[15];
      6'h30: e = 1'b1;
      default: e = 1'b0;
    endcase
    if (c > 6'h34 && c != 6'h39 && c != 6'h3A) e = !e;
    return e;
  endfunction

  task automatic period(output int p);
    int n, k, t;
    k = 0;
    t = 0;
    p = 0;
    for (n = 0; n < 400 && k < 4; n++) begin
      @(negedge aclk);
      if (fb_out === 1'b1) begin
        k++;
        if (k == 3) t = n;
        if (k == 4) p = n - t;
      end
    end
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          p, k, c, ps;
    {aresetn, awv, wv, bready, arv, rready} = '0;
    ce = 1'b1;
    {awaddr, araddr, wdata, swc, src} = '0;
    mainc = 13'h1;
    mismatches = 0;
    checks_done = 0;
    void'($urandom(79878));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(8'h58, 32'h06);
    rdchk(8'h5C, 32'h00);
    rdchk(8'h84, 32'h00);
    axi_rd(8'hFC, d, r);
    check("unmapped rresp", {30'h0, r}, 32'h3);
    check("unmapped rdata", d, 32'h0);
    for (c = 0; c < 8; c++) begin
      k = int'(c == 0 || c == 1 || c == 7);
      d = {24'h0, 4'($urandom), k[0], c[2:0]};
      wrchk(8'h58, d, 2'h0);
      rdchk(8'h58, d);
      @(posedge aclk);
      mainc <= k[0] ? 13'h5 : 13'h1;
      for (ps = 0; ps < 2; ps++) begin
        @(posedge aclk);
        swc <= ps[5:0];
        period(p);
        check("period", p, div_exp(c[2:0], ps[0]));
      end
    end
    wrchk(8'h58, 32'h01, 2'h0);
    @(posedge aclk);
    mainc <= 13'h5;
    period(p);
    check("period", p, 10);
    wrchk(8'h58, 32'h03, 2'h0);
    @(posedge aclk);
    mainc <= 13'h3;
    period(p);
    check("period", p, 13);
    for (ps = 0; ps < 2; ps++)
      for (c = 0; c < 64; c++) begin
        if (ps == 1 && !(c inside {[33:38], [49:51]})) continue;
        wrchk(8'h5C, {24'h0, c[5:0], 2'($urandom)}, 2'h0);
        k = $urandom;
        src <= {k[15:7], ps[0], k[5:0]};
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        if (c != 3 && c != 4)
          check("status_pin", pin, pin_exp(c[5:0], src));
        check("irq masked", irq, 1'b0);
      end
    axi_rd(8'h80, d, r);
    wrchk(8'h84, 32'h08, 2'h0);
    rdchk(8'h84, 32'h08);
    wrchk(8'h5C, 32'h84, 2'h0);
    wrchk(8'h74, 32'h80, 2'h0);
    wrchk(8'h5C, 32'hC0, 2'h0);
    rdchk(8'h5C, 32'h84);
    @(negedge aclk);
    check("irq", irq, 1'b1);
    rdchk(8'h80, 32'h08);
    @(negedge aclk);
    check("irq", irq, 1'b0);
    wrchk(8'h74, 32'h00, 2'h0);
    wrchk(8'h5C, 32'hC0, 2'h0);
    rdchk(8'h5C, 32'hC0);
    repeat (2) @(negedge aclk);
    check("status_pin", pin, 1'b1);
    wrchk(8'h5C, 32'hB4, 2'h0);
    @(posedge aclk);
    src[13] <= 1'b1;
    repeat (2) @(negedge aclk);
    check("status_pin", pin, 1'b1);
    @(posedge aclk);
    ce <= 1'b0;
    src[13] <= 1'b0;
    @(negedge aclk);
    k = fb_out;
    repeat (20) begin
      @(negedge aclk);
      check("frozen fb", fb_out, k[0]);
      check("frozen pin", pin, 1'b1);
    end
    @(posedge aclk);
    ce <= 1'b1;
    repeat (2) @(negedge aclk);
    check("status_pin", pin, 1'b0);
    wrchk(8'hFC, 32'h5A, 2'h3);
    tally_and_finish();
  end
endmodule // prescaler_and_status_pin_mux_bench
`default_nettype wire
